// ==== design/alu_flags.sv ====
module alu_flags
    import cpu_regs_pkg::*;
(
    input  wire alu_op_t    aluOp,
    input  wire logic [7:0] opA,
    input  wire logic [7:0] opB,
    input  wire logic       carryIn,
    input  wire logic       shiftCarry,
    output logic [7:0]      result,
    output logic            vOut,
    output logic            hOut,
    output logic            cOut,
    output logic            updV,
    output logic            updH,
    output logic            updC
);
    logic [8:0] wide;
    logic       isSub;

    always_comb begin
        isSub = (aluOp == ALU_SUB) || (aluOp == ALU_SBC);
        case (aluOp)
            ALU_ADD:   wide = {1'b0, opA} + {1'b0, opB};
            ALU_ADC:   wide = {1'b0, opA} + {1'b0, opB} + {8'h00, carryIn};
            ALU_SUB:   wide = {1'b0, opA} - {1'b0, opB};
            ALU_SBC:   wide = {1'b0, opA} - {1'b0, opB} - {8'h00, carryIn};
            default:   wide = {1'b0, opB};
        endcase
        result = wide[7:0];
        updV   = 1'b1;
        updH   = (aluOp == ALU_ADD) || (aluOp == ALU_ADC);
        updC   = (aluOp != ALU_PASS);
        cOut   = (aluOp == ALU_SHIFT) ? shiftCarry : wide[8];
        hOut   = (opA[3] & opB[3]) | (opB[3] & ~result[3])
               | (~result[3] & opA[3]);
        if (isSub) begin
            vOut = (opA[7] & ~opB[7] & ~result[7])
                 | (~opA[7] & opB[7] & result[7]);
        end else if (aluOp == ALU_SHIFT) begin
            vOut = result[7] ^ shiftCarry;
        end else if (aluOp == ALU_PASS) begin
            vOut = 1'b0;
        end else begin
            vOut = (opA[7] & opB[7] & ~result[7])
                 | (~opA[7] & ~opB[7] & result[7]);
        end
    end

endmodule

// ==== design/cpu_register_file.sv ====
module cpu_register_file
    import cpu_regs_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              rst_b,
    input  wire acc_sel_t          accSel,
    input  wire logic [7:0]        accIn,
    input  wire logic              idxHiWe,
    input  wire logic              idxLoWe,
    input  wire logic [15:0]       idxIn,
    input  wire sp_op_t            spOp,
    input  wire logic [15:0]       spIn,
    input  wire logic [7:0]        spAdj,
    input  wire pc_op_t            pcOp,
    input  wire logic [15:0]       pcIn,
    input  wire ccr_op_t           ccrOp,
    input  wire logic [7:0]        ccrIn,
    input  wire alu_op_t           aluOp,
    input  wire logic [7:0]        aluB,
    input  wire logic              shiftCarry,
    input  wire logic              addrReq,
    input  wire addr_mode_t        addrMode,
    input  wire logic [15:0]       addrOfs,
    input  wire logic [7:0]        vecData,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [7:0]             accOut,
    output logic [15:0]            indexOut,
    output logic [15:0]            spOut,
    output logic [15:0]            pcOut,
    output logic [7:0]             ccrOut,
    output logic [15:0]            effAddr,
    output logic                   effAddrValid,
    output logic [15:0]            vecAddr,
    output logic                   vecRd,
    output logic                   coreReady,
    output logic                   condLess,
    output logic                   condLessEq,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr
);
    typedef enum logic [1:0] {VS_HI, VS_LO, VS_RUN} vec_state_t;

    vec_state_t  vecState_q;
    logic [7:0]  acc_q, idxHi_q, idxLo_q, ccr_q, ccr_d;
    logic [15:0] sp_q, pc_q, effAddr_q, vecAddr_q;
    logic        effValid_q, vecRd_q, ready_q, less_q, lessEq_q;
    logic [31:0] prdata_q;
    logic        pready_q, pslverr_q, guard_q, wrap_q;
    logic [7:0]  aluRes, decRes;
    logic        aluV, aluH, aluC, updV, updH, updC, decC;
    logic        apbAccess, apbDone, wrapEvent, wrapClr;
    logic [15:0] idxPair;

    assign idxPair = {idxHi_q, idxLo_q};

    ////////////////////////////////////////////////////////////////////////
    // arithmetic helpers
    alu_flags u_alu (
        .aluOp      (aluOp),
        .opA        (acc_q),
        .opB        (aluB),
        .carryIn    (ccr_q[CC_C]),
        .shiftCarry (shiftCarry),
        .result     (aluRes),
        .vOut       (aluV),
        .hOut       (aluH),
        .cOut       (aluC),
        .updV       (updV),
        .updH       (updH),
        .updC       (updC)
    );

    decimal_adjust u_dec (
        .accIn  (acc_q),
        .hFlag  (ccr_q[CC_H]),
        .cFlag  (ccr_q[CC_C]),
        .result (decRes),
        .cOut   (decC)
    );

    ////////////////////////////////////////////////////////////////////////
    // reset vector fetch; datapath requests are ignored until it is done
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            vecState_q <= VS_HI;
            vecAddr_q  <= VEC_HI_ADDR;
            vecRd_q    <= 1'b1;
            ready_q    <= 1'b0;
        end else begin
            case (vecState_q)
                VS_HI: begin
                    vecState_q <= VS_LO;
                    vecAddr_q  <= VEC_LO_ADDR;
                end
                VS_LO: begin
                    vecState_q <= VS_RUN;
                    vecRd_q    <= 1'b0;
                    ready_q    <= 1'b1;
                end
                VS_RUN: begin
                    vecState_q <= VS_RUN;
                end
                default: begin
                    vecState_q <= VS_HI;
                    vecAddr_q  <= VEC_HI_ADDR;
                    vecRd_q    <= 1'b1;
                    ready_q    <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // program counter
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pc_q <= PC_RESET;
        end else if (vecState_q == VS_HI) begin
            pc_q <= {vecData, pc_q[7:0]};
        end else if (vecState_q == VS_LO) begin
            pc_q <= {pc_q[15:8], vecData};
        end else begin
            case (pcOp)
                PC_INC:  pc_q <= pc_q + 16'h0001;
                PC_LOAD: pc_q <= pcIn;
                default: pc_q <= pc_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // accumulator and index pair
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            acc_q <= ACC_RESET;
        end else if (ready_q) begin
            case (accSel)
                ACC_DATA: acc_q <= accIn;
                ACC_ALU:  acc_q <= aluRes;
                ACC_DEC:  acc_q <= decRes;
                default:  acc_q <= acc_q;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            idxHi_q <= IDX_BYTE_RESET;
            idxLo_q <= IDX_BYTE_RESET;
        end else if (ready_q) begin
            if (idxHiWe) begin
                idxHi_q <= idxIn[15:8];
            end
            if (idxLoWe) begin
                idxLo_q <= idxIn[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // stack pointer
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sp_q <= SP_RESET;
        end else if (ready_q) begin
            case (spOp)
                SP_LOAD: sp_q <= spIn;
                SP_PUSH: sp_q <= sp_q - 16'h0001;
                SP_PULL: sp_q <= sp_q + 16'h0001;
                SP_TOP:  sp_q <= {sp_q[15:8], SP_TOP_LOW};
                SP_ADD:  sp_q <= sp_q + {{8{spAdj[7]}}, spAdj};
                default: sp_q <= sp_q;
            endcase
        end
    end

    // a wrap means the stack ran off either end of the space
    assign wrapEvent = ready_q && guard_q
                     && (((spOp == SP_PUSH) && (sp_q == 16'h0000))
                     || ((spOp == SP_PULL) && (sp_q == 16'hffff)));

    ////////////////////////////////////////////////////////////////////////
    // condition codes
    always_comb begin
        ccr_d = ccr_q;
        case (ccrOp)
            CC_LOAD: ccr_d = ccrIn;
            CC_ALU: begin
                ccr_d[CC_N] = aluRes[7];
                ccr_d[CC_Z] = (aluRes == 8'h00);
                if (updV) begin
                    ccr_d[CC_V] = aluV;
                end
                if (updH) begin
                    ccr_d[CC_H] = aluH;
                end
                if (updC) begin
                    ccr_d[CC_C] = aluC;
                end
            end
            CC_DEC: begin
                ccr_d[CC_N] = decRes[7];
                ccr_d[CC_Z] = (decRes == 8'h00);
                ccr_d[CC_C] = decC;
            end
            CC_SET_I: ccr_d[CC_I] = 1'b1;
            CC_CLR_I: ccr_d[CC_I] = 1'b0;
            default:  ccr_d = ccr_q;
        endcase
        ccr_d = ccr_d | CCR_ONES;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ccr_q    <= CCR_RESET;
            less_q   <= 1'b0;
            lessEq_q <= 1'b0;
        end else if (ready_q) begin
            ccr_q    <= ccr_d;
            less_q   <= ccr_d[CC_N] ^ ccr_d[CC_V];
            lessEq_q <= ccr_d[CC_Z] | (ccr_d[CC_N] ^ ccr_d[CC_V]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // operand address; index pair or stack pointer as base
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            effAddr_q  <= 16'h0000;
            effValid_q <= 1'b0;
        end else begin
            effValid_q <= addrReq && ready_q;
            if (addrReq && ready_q) begin
                case (addrMode)
                    AM_IX:   effAddr_q <= idxPair;
                    AM_IX1:  effAddr_q <= idxPair + {8'h00, addrOfs[7:0]};
                    AM_IX2:  effAddr_q <= idxPair + addrOfs;
                    AM_SP1:  effAddr_q <= sp_q + {8'h00, addrOfs[7:0]};
                    AM_SP2:  effAddr_q <= sp_q + addrOfs;
                    default: effAddr_q <= idxPair;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb slave: only control and status live here, core registers
    // stay off the bus
    assign apbAccess = psel && penable && !pready_q;
    assign apbDone   = psel && penable && pready_q;
    assign wrapClr   = apbDone && pwrite && (paddr == STAT_OFS)
                     && pwdata[STAT_WRAP_BIT];

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= apbAccess;
            pslverr_q <= apbAccess && (paddr != CTRL_OFS)
                       && (paddr != STAT_OFS);
            if (apbAccess && !pwrite) begin
                prdata_q <= 32'h0000_0000;
                if (paddr == CTRL_OFS) begin
                    prdata_q[CTRL_GUARD_BIT] <= guard_q;
                end else if (paddr == STAT_OFS) begin
                    prdata_q[STAT_WRAP_BIT]  <= wrap_q;
                    prdata_q[STAT_READY_BIT] <= ready_q;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            guard_q <= CTRL_RESET;
        end else if (apbDone && pwrite && (paddr == CTRL_OFS)) begin
            guard_q <= pwdata[CTRL_GUARD_BIT];
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wrap_q <= 1'b0;
        end else begin
            wrap_q <= wrapEvent || (wrap_q && !wrapClr);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign accOut       = acc_q;
    assign indexOut     = idxPair;
    assign spOut        = sp_q;
    assign pcOut        = pc_q;
    assign ccrOut       = ccr_q;
    assign effAddr      = effAddr_q;
    assign effAddrValid = effValid_q;
    assign vecAddr      = vecAddr_q;
    assign vecRd        = vecRd_q;
    assign coreReady    = ready_q;
    assign condLess     = less_q;
    assign condLessEq   = lessEq_q;
    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    property p_ccr_ones;
        ccrOp == CC_LOAD && ready_q |=> ccr_q[6:5] == 2'b11;
    endproperty
    a_ccr_ones: assert property (p_ccr_ones)
        else $error("condition bits 6 and 5 not one");

    property p_push;
        spOp == SP_PUSH && ready_q |=> sp_q == $past(sp_q) - 16'h0001;
    endproperty
    a_push: assert property (p_push)
        else $error("push did not decrement stack pointer");

    property p_sp_top;
        spOp == SP_TOP && ready_q
            |=> sp_q[7:0] == SP_TOP_LOW && sp_q[15:8] == $past(sp_q[15:8]);
    endproperty
    a_sp_top: assert property (p_sp_top)
        else $error("reset-stack instruction wrong");

    property p_pc_inc;
        pcOp == PC_INC && ready_q |=> pc_q == $past(pc_q) + 16'h0001;
    endproperty
    a_pc_inc: assert property (p_pc_inc)
        else $error("program counter did not advance");

    property p_pc_load;
        pcOp == PC_LOAD && ready_q |=> pc_q == $past(pcIn);
    endproperty
    a_pc_load: assert property (p_pc_load)
        else $error("program counter not loaded");

    property p_vector;
        vecState_q == VS_HI
            |=> vecAddr_q == VEC_LO_ADDR ##1 pc_q == {$past(vecData, 2),
                                                  $past(vecData)}
                && ready_q;
    endproperty
    a_vector: assert property (p_vector)
        else $error("reset vector not loaded");

    property p_ready_state;
        $rose(ready_q) |-> sp_q == SP_RESET && ccr_q[CC_I];
    endproperty
    a_ready_state: assert property (p_ready_state)
        else $error("reset presets wrong");

    property p_half;
        ccrOp == CC_ALU && aluOp == ALU_ADD && ready_q
            && ({1'b0, acc_q[3:0]} + {1'b0, aluB[3:0]}) > 5'h0f
            |=> ccr_q[CC_H];
    endproperty
    a_half: assert property (p_half)
        else $error("half carry missed");

    property p_zero;
        ccrOp == CC_ALU && ready_q |=> ccr_q[CC_Z] == ($past(aluRes) == 0);
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero flag wrong");

    property p_ovf;
        ccrOp == CC_ALU && aluOp == ALU_ADD && ready_q
            && acc_q[7] == aluB[7] && aluRes[7] != acc_q[7]
            |=> ccr_q[CC_V] ##1 1'b1;
    endproperty
    a_ovf: assert property (p_ovf)
        else $error("overflow missed");

    property p_index_addr;
        addrReq && ready_q && addrMode == AM_IX
            |=> effAddrValid && effAddr == $past(idxPair);
    endproperty
    a_index_addr: assert property (p_index_addr)
        else $error("indexed address wrong");

    property p_sp_addr;
        addrReq && ready_q && addrMode == AM_SP2
            |=> effAddr == $past(sp_q) + $past(addrOfs);
    endproperty
    a_sp_addr: assert property (p_sp_addr)
        else $error("stack relative address wrong");

    c_push:  cover property (spOp == SP_PUSH && ready_q);
    c_dec:   cover property (ccrOp == CC_DEC && ready_q && decC);
    c_ready: cover property ($rose(ready_q));
    c_apb:   cover property (apbDone && pwrite);

endmodule

// ==== design/cpu_regs_pkg.sv ====
package cpu_regs_pkg;

    ////////////////////////////////////////////////////////////////////////
    // reset values and fixed addresses
    localparam logic [15:0] SP_RESET       = 16'h00ff;
    localparam logic [7:0]  SP_TOP_LOW     = 8'hff;
    localparam logic [15:0] PC_RESET       = 16'h0000;
    localparam logic [15:0] VEC_HI_ADDR    = 16'hfffe;
    localparam logic [15:0] VEC_LO_ADDR    = 16'hffff;
    localparam logic [7:0]  ACC_RESET      = 8'h00;
    localparam logic [7:0]  IDX_BYTE_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // condition code layout
    localparam int          CC_C      = 0;
    localparam int          CC_Z      = 1;
    localparam int          CC_N      = 2;
    localparam int          CC_I      = 3;
    localparam int          CC_H      = 4;
    localparam int          CC_V      = 7;
    localparam logic [7:0]  CCR_ONES  = 8'h60;
    localparam logic [7:0]  CCR_RESET = 8'h68;

    ////////////////////////////////////////////////////////////////////////
    // decimal adjust
    localparam logic [7:0]  DEC_LO_FIX = 8'h06;
    localparam logic [7:0]  DEC_HI_FIX = 8'h60;
    localparam logic [3:0]  BCD_DIGIT_MAX = 4'h9;
    localparam logic [7:0]  BCD_BYTE_MAX  = 8'h99;

    ////////////////////////////////////////////////////////////////////////
    // apb map
    localparam int          APB_AW         = 12;
    localparam logic [11:0] CTRL_OFS       = 12'h000;
    localparam logic [11:0] STAT_OFS       = 12'h004;
    localparam int          CTRL_GUARD_BIT = 0;
    localparam int          STAT_WRAP_BIT  = 0;
    localparam int          STAT_READY_BIT = 1;
    localparam logic        CTRL_RESET     = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // operation selects
    typedef enum logic [1:0] {ACC_NONE, ACC_DATA, ACC_ALU, ACC_DEC} acc_sel_t;
    typedef enum logic [2:0] {SP_NONE, SP_LOAD, SP_PUSH, SP_PULL, SP_TOP,
                              SP_ADD} sp_op_t;
    typedef enum logic [1:0] {PC_NONE, PC_INC, PC_LOAD} pc_op_t;
    typedef enum logic [2:0] {CC_NONE, CC_LOAD, CC_ALU, CC_DEC, CC_SET_I,
                              CC_CLR_I} ccr_op_t;
    typedef enum logic [2:0] {ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_PASS,
                              ALU_SHIFT} alu_op_t;
    typedef enum logic [2:0] {AM_IX, AM_IX1, AM_IX2, AM_SP1,
                              AM_SP2} addr_mode_t;

endpackage

// ==== design/decimal_adjust.sv ====
module decimal_adjust
    import cpu_regs_pkg::*;
(
    input  wire logic [7:0] accIn,
    input  wire logic       hFlag,
    input  wire logic       cFlag,
    output logic [7:0]      result,
    output logic            cOut
);
    logic [7:0] fix;

    // correction chosen from both flags and the digits themselves
    always_comb begin
        fix  = 8'h00;
        cOut = 1'b0;
        if (cFlag || (accIn > BCD_BYTE_MAX)) begin
            fix  = fix | DEC_HI_FIX;
            cOut = 1'b1;
        end
        if (hFlag || (accIn[3:0] > BCD_DIGIT_MAX)) begin
            fix = fix | DEC_LO_FIX;
        end
        result = accIn + fix;
    end

endmodule

// ==== verification/tb_top.sv ====
module tb_top
    import cpu_regs_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] VHI = 8'hc1;
    localparam logic [7:0] VLO = 8'h3a;
    logic              clock = 1'b0;
    logic              rst_b = 1'b0;
    acc_sel_t          accSel = ACC_NONE;
    sp_op_t            spOp = SP_NONE;
    pc_op_t            pcOp = PC_NONE;
    ccr_op_t           ccrOp = CC_NONE;
    alu_op_t           aluOp = ALU_ADD;
    addr_mode_t        addrMode = AM_IX;
    logic [7:0]        accIn = 8'h00, aluB = 8'h00, spAdj = 8'h00;
    logic [7:0]        ccrIn = 8'h00;
    logic [15:0]       idxIn = 16'h0000, spIn = 16'h0000;
    logic [15:0]       pcIn = 16'h0000, addrOfs = 16'h0000;
    logic              idxHiWe = 1'b0, idxLoWe = 1'b0, shiftCarry = 1'b0;
    logic              addrReq = 1'b0, psel = 1'b0, penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [APB_AW-1:0] paddr = 12'h000;
    logic [31:0]       pwdata = 32'h00000000, prdata, rA, rB, rd;
    logic [7:0]        accOut, ccrOut, vecData, a, cc, t;
    logic [15:0]       indexOut, spOut, pcOut, effAddr, vecAddr;
    logic [15:0]       hx, sp, pc, ea;
    logic              effAddrValid, vecRd, coreReady, condLess, condLessEq;
    logic              pready, pslverr, er, eav, v, h;
    logic [8:0]        r;
    int                seed = 49480, cyc = 0, failCount = 0, nChecks = 0;
    ccr_op_t           ccl[4] = '{CC_NONE, CC_LOAD, CC_SET_I, CC_CLR_I};
    cpu_register_file DUT (
        .clock, .rst_b, .accSel, .accIn, .idxHiWe, .idxLoWe, .idxIn, .spOp,
        .spIn, .spAdj, .pcOp, .pcIn, .ccrOp, .ccrIn, .aluOp, .aluB,
        .shiftCarry, .addrReq, .addrMode, .addrOfs, .vecData, .psel,
        .penable, .pwrite, .paddr, .pwdata, .accOut, .indexOut, .spOut,
        .pcOut, .ccrOut, .effAddr, .effAddrValid, .vecAddr, .vecRd,
        .coreReady, .condLess, .condLessEq, .prdata, .pready, .pslverr
    );
    vec_mem #(.VEC_HI(VHI), .VEC_LO(VLO)) mem (.vecAddr, .vecRd, .vecData);
    always #20 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            failCount++;
            giveVerdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] got, exp);
        nChecks++;
        if (got !== exp) begin
            failCount++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", nChecks, failCount);
        if (failCount == 0 && nChecks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] ad, input int wd);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic idle();
        accSel <= ACC_NONE;
        spOp <= SP_NONE;
        pcOp <= PC_NONE;
        ccrOp <= CC_NONE;
        {idxHiWe, idxLoWe, addrReq} <= 3'b000;
    endtask
    // ops idle first: edge 3 after release already takes requests
    task automatic boot();
        idle();
        rst_b <= 1'b0;
        repeat (4) @(posedge clock);
        check("vecAddr", vecAddr, VEC_HI_ADDR);
        check("vecRd", vecRd, 1'b1);
        check("mask", ccrOut[CC_I], 1'b1);
        rst_b <= 1'b1;
        while (coreReady !== 1'b1) @(posedge clock);
        check("vecRd", vecRd, 1'b0);
        {a, hx, sp, pc, cc} = {ACC_RESET, 16'h0000, SP_RESET, VHI, VLO,
                               CCR_RESET};
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic step();
        @(posedge clock);
        eav = addrReq;
        ea = (addrMode < AM_SP1) ? hx : sp;
        if (addrMode == AM_IX1 || addrMode == AM_SP1)
            ea = ea + {8'h00, addrOfs[7:0]};
        else if (addrMode != AM_IX)
            ea = ea + addrOfs;
        if (ccrOp == CC_ALU) begin
            r = (aluOp < ALU_SUB) ? a + aluB + (aluOp == ALU_ADC & cc[CC_C])
                                  : a - aluB - (aluOp == ALU_SBC & cc[CC_C]);
            v = ((aluOp > ALU_ADC) ^ ~(a[7] ^ aluB[7])) & (r[7] ^ a[7]);
            if (aluOp > ALU_SBC) begin
                r = {(aluOp == ALU_SHIFT) ? shiftCarry : cc[CC_C], aluB};
                v = (aluOp == ALU_SHIFT) & (aluB[7] ^ shiftCarry);
            end
            h = (aluOp > ALU_ADC) ? cc[CC_H]
                : ({1'b0, a[3:0]} + aluB[3:0] + (aluOp == ALU_ADC & cc[CC_C]))
                  > 5'h0f;
            cc = {v, 2'b11, h, cc[CC_I], r[7], r[7:0] == 8'h00, r[8]};
            a = r[7:0];
        end else if (ccrOp == CC_DEC) begin
            t = a;
            if (cc[CC_C] || a > BCD_BYTE_MAX) begin
                t = t + DEC_HI_FIX;
                cc[CC_C] = 1'b1;
            end
            if (cc[CC_H] || a[3:0] > BCD_DIGIT_MAX)
                t = t + DEC_LO_FIX;
            {cc[CC_N], cc[CC_Z], a} = {t[7], t == 8'h00, t};
        end else begin
            if (ccrOp == CC_LOAD) cc = ccrIn | CCR_ONES;
            if (ccrOp == CC_SET_I || ccrOp == CC_CLR_I)
                cc[CC_I] = (ccrOp == CC_SET_I);
            a = (accSel == ACC_DATA) ? accIn : a;
        end
        if (idxHiWe) hx[15:8] = idxIn[15:8];
        if (idxLoWe) hx[7:0] = idxIn[7:0];
        case (spOp)
            SP_LOAD: sp = spIn;
            SP_PUSH: sp = sp - 16'h0001;
            SP_PULL: sp = sp + 16'h0001;
            SP_TOP:  sp[7:0] = SP_TOP_LOW;
            SP_ADD:  sp = sp + {{8{spAdj[7]}}, spAdj};
            default: ;
        endcase
        pc = (pcOp == PC_INC) ? pc + 16'h0001 : (pcOp == PC_LOAD) ? pcIn : pc;
        rA = $random(seed);
        rB = $random(seed);
        {accIn, aluB, idxIn} <= rA;
        {ccrIn, spAdj, spIn} <= rB;
        {pcIn, addrOfs} <= {rB[31:16], rA[31:16]};
        {idxHiWe, idxLoWe, addrReq, shiftCarry} <= rB[3:0];
        aluOp <= alu_op_t'(rA[5:3] > 3'd5 ? 3'd0 : rA[5:3]);
        spOp <= sp_op_t'(rA[2:0] > 3'd5 ? 3'd2 : rA[2:0]);
        pcOp <= pc_op_t'(rB[7:6] == 2'd3 ? 2'd1 : rB[7:6]);
        addrMode <= addr_mode_t'(rB[10:8] > 3'd4 ? 3'd0 : rB[10:8]);
        accSel <= acc_sel_t'(rB[12:11] == 2'd0 ? 2'd3
                             : rB[12:11] == 2'd3 ? 2'd0 : rB[12:11]);
        ccrOp <= rB[12:11] == 2'd2 ? CC_ALU : rB[12:11] == 2'd0 ? CC_DEC
                 : ccl[rB[14:13]];
        #1;
        check("acc", accOut, a);
        check("index", indexOut, hx);
        check("sp", spOut, sp);
        check("pc", pcOut, pc);
        check("ccr", ccrOut, cc);
        check("ones", ccrOut[6:5], 2'b11);
        check("less", condLess, cc[CC_N] ^ cc[CC_V]);
        check("lessEq", condLessEq, cc[CC_Z]|cc[CC_N]^cc[CC_V]);
        check("valid", effAddrValid, eav);
        if (eav) check("addr", effAddr, ea);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        boot();
        apb(1'b0, CTRL_OFS, 0);
        check("ctrl", rd, 32'h00000000);
        apb(1'b1, CTRL_OFS, 1);
        apb(1'b0, CTRL_OFS, 0);
        check("ctrl", rd, 32'h00000001);
        spIn <= 16'h0000;
        spOp <= SP_LOAD;
        step();
        spOp <= SP_PUSH;
        step();
        idle();
        apb(1'b0, STAT_OFS, 0);
        check("stat", rd, 32'h00000003);
        apb(1'b1, STAT_OFS, 1);
        apb(1'b0, STAT_OFS, 0);
        check("stat", rd, 32'h00000002);
        apb(1'b0, 12'h008, 0);
        check("unmapped", rd, 32'h00000000);
        check("slverr", er, 1'b1);
        repeat (500) step();
        boot();
        repeat (100) step();
        giveVerdict();
    end
endmodule

// ==== verification/vec_mem.sv ====
module vec_mem
    import cpu_regs_pkg::*;
#(
    parameter logic [7:0] VEC_HI = 8'hc1,
    parameter logic [7:0] VEC_LO = 8'h3a
) (
    input  wire logic [15:0] vecAddr,
    input  wire logic        vecRd,
    output logic [7:0]       vecData
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle bus shows the inverse of the last byte, so stale reads differ
    always_comb begin
        if (!vecRd)
            vecData = ~VEC_LO;
        else if (vecAddr == VEC_HI_ADDR)
            vecData = VEC_HI;
        else if (vecAddr == VEC_LO_ADDR)
            vecData = VEC_LO;
        else
            vecData = vecAddr[7:0] ^ 8'h5a;
    end
endmodule
